/* core/gbsl_bank.sv */
// Purpose: ten-pin configurable I/O bank with service indicator on pin 0
// Assumes: pin inputs synchronous to clk_i; firmware drives the control ports
// Notes: outputs are registered; read data is the input pin sampled on read, or the commanded level for output pins;
//        pad drive follows a configuration write by two clock edges;
//        a read in the write cycle still sees the old configuration;
//        pins other than pin 0 ignore the alternate select;
//        the pattern input is sampled on every clock
`timescale 1ns/1ps
`include "gbsl_regs.svh"
module gbsl_bank #(
    parameter int NPINS = `GBSL_NPINS,
    parameter int TICK_CYC = `GBSL_TICK_CYC
) (
    input wire logic clk_i,
    input wire logic resetn_i,
    input wire logic [NPINS-1:0] pin_i,
    output logic [NPINS-1:0] pin_o,
    output logic [NPINS-1:0] pin_oe_o,
    input wire logic [NPINS-1:0] dir_wr_i,
    input wire logic [NPINS-1:0] dir_val_i,
    input wire logic [NPINS-1:0] alt_wr_i,
    input wire logic [NPINS-1:0] alt_val_i,
    input wire logic [NPINS-1:0] out_wr_i,
    input wire logic [NPINS-1:0] out_val_i,
    input wire logic rd_i,
    output logic [NPINS-1:0] rd_data_o,
    output logic rd_valid_o,
    input wire gbsl_pkg::gbsl_pattern_t pattern_i
);
    import gbsl_pkg::*;

    // Reset images and indicator position, sized to the bank
    localparam logic [NPINS-1:0] RST_DIR = NPINS'(`GBSL_RST_DIR);
    localparam logic [NPINS-1:0] RST_ALT = NPINS'(`GBSL_RST_ALT);
    localparam logic [NPINS-1:0] RST_OUT = NPINS'(`GBSL_RST_OUT);
    localparam int IND_PIN = `GBSL_IND_PIN;

    // Configuration registers written by firmware
    logic [NPINS-1:0] dir_ff;
    logic [NPINS-1:0] alt_ff;
    logic [NPINS-1:0] out_ff;

    // Registered pad drive and enable
    logic [NPINS-1:0] pin_o_ff;
    logic [NPINS-1:0] oe_ff;

    // Registered read answer
    logic [NPINS-1:0] rd_ff;
    logic rdv_ff;

    // Lamp state from the pattern generator
    logic lamp;

    // Alternate function capability and drive
    wire [NPINS-1:0] alt_mask;
    wire [NPINS-1:0] alt_drv;

    // Per-pin mode decode
    wire [NPINS-1:0] is_alt;
    wire [NPINS-1:0] is_out;
    wire [NPINS-1:0] is_in;

    // Read sources per pin
    wire [NPINS-1:0] rd_cmd;
    wire [NPINS-1:0] rd_pad;

    // Next configuration values
    wire [NPINS-1:0] nxt_dir;
    wire [NPINS-1:0] nxt_alt;
    wire [NPINS-1:0] nxt_out;

    // Next drive and read values
    wire [NPINS-1:0] nxt_pin;
    wire [NPINS-1:0] nxt_oe;
    wire [NPINS-1:0] nxt_rd;
    wire nxt_rdv;

    // Indicator pattern generator
    gbsl_blinker #(
        .TICK_CYC(TICK_CYC)
    ) u_blinker (
        .clk_i(clk_i),
        .resetn_i(resetn_i),
        .pattern_i(pattern_i),
        .lamp_o(lamp)
    );

    // Only the indicator pin has an alternate function
    assign alt_mask = NPINS'(1) << IND_PIN;

    // Inverting lamp stage outside, so the pad is low while lit
    assign alt_drv = {NPINS{~lamp}} & alt_mask;

    // Read strobe becomes a one-cycle valid pulse
    assign nxt_rdv = rd_i;

    // Per-pin decode, write merge, drive and read selection
    genvar gi;
    for (gi = 0; gi < NPINS; gi = gi + 1)
    begin : g_pin
        // Mode of this pin, alternate overrides direction
        assign is_alt[gi] = alt_ff[gi];
        assign is_out[gi] = dir_ff[gi] & ~alt_ff[gi];
        assign is_in[gi] = ~dir_ff[gi] & ~alt_ff[gi];

        // Strobed bits take the new value, others keep theirs
        assign nxt_dir[gi] = dir_wr_i[gi] ? dir_val_i[gi] : dir_ff[gi];
        assign nxt_out[gi] = out_wr_i[gi] ? out_val_i[gi] : out_ff[gi];

        // Only the indicator pin can hold the alternate select
        assign nxt_alt[gi] = alt_mask[gi] &
                             (alt_wr_i[gi] ? alt_val_i[gi] : alt_ff[gi]);

        // Drive level: internal function or commanded value
        assign nxt_pin[gi] = is_alt[gi] ? alt_drv[gi] : out_ff[gi];

        // Driver on for outputs and the alternate function
        assign nxt_oe[gi] = is_alt[gi] | is_out[gi];

        // Read value: pad level for inputs, command for outputs
        assign rd_cmd[gi] = is_out[gi] & out_ff[gi];
        assign rd_pad[gi] = is_in[gi] & pin_i[gi];
        assign nxt_rd[gi] = rd_cmd[gi] | rd_pad[gi];
    end

    // Direction register, every pin comes up as an input
    always_ff @(posedge clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            dir_ff <= RST_DIR;
        end
        else
        begin
            dir_ff <= nxt_dir;
        end
    end

    // Alternate select register
    always_ff @(posedge clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            alt_ff <= RST_ALT;
        end
        else
        begin
            alt_ff <= nxt_alt;
        end
    end

    // Commanded output level register
    always_ff @(posedge clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            out_ff <= RST_OUT;
        end
        else
        begin
            out_ff <= nxt_out;
        end
    end

    // Registered pad drive level
    always_ff @(posedge clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            pin_o_ff <= '0;
        end
        else
        begin
            pin_o_ff <= nxt_pin;
        end
    end

    // Registered pad driver enable
    always_ff @(posedge clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            oe_ff <= '0;
        end
        else
        begin
            oe_ff <= nxt_oe;
        end
    end

    // Read answer, held until the next read
    always_ff @(posedge clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            rd_ff <= '0;
        end
        else if (rd_i)
        begin
            rd_ff <= nxt_rd;
        end
    end

    // Read valid pulse
    always_ff @(posedge clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            rdv_ff <= 1'b0;
        end
        else
        begin
            rdv_ff <= nxt_rdv;
        end
    end

    // Pad drive straight from flip-flops
    assign pin_o = pin_o_ff;
    assign pin_oe_o = oe_ff;

    // Read answer straight from flip-flops
    assign rd_data_o = rd_ff;
    assign rd_valid_o = rdv_ff;
endmodule : gbsl_bank

/* common/gbsl_regs.svh */
// Purpose: constants for the ten-pin bank and its service indicator
// Assumes: 40 MHz clock, 1 ms reference tick
// Notes: times in ms, tick counts derived below
//
// Behaviour
// - After reset every pin is an input with its driver off.
// - An input pin is read only and returns the level sampled at the read.
// - An output pin takes written levels and a query returns that level.
// - A pin in alternate mode is driven by internal logic; pin 0 shows the indicator.
// - An output pin drives both high and low levels.
// - The indicator shows off, on during a call, and two blink patterns.
// - Searching, unregistered or shutting down blinks 1 s period, 0.5 s lit.
// - Registered with full service blinks 3 s period, 0.3 s lit.
// - The indicator pin level is the inverse of the lamp state.
`ifndef GBSL_REGS_SVH
`define GBSL_REGS_SVH
`define GBSL_CLK_HZ 40000000
`define GBSL_TICK_MS 1
`define GBSL_TICK_CYC (`GBSL_CLK_HZ / 1000 * `GBSL_TICK_MS)
`define GBSL_FAST_PER_MS 1000
`define GBSL_FAST_ON_MS 500
`define GBSL_SLOW_PER_MS 3000
`define GBSL_SLOW_ON_MS 300
`define GBSL_NPINS 10
`define GBSL_IND_PIN 0
`define GBSL_RST_DIR 10'h000
`define GBSL_RST_OUT 10'h000
`define GBSL_RST_ALT 10'h000
`endif

/* common/gbsl_pkg.sv */
// Purpose: types for the pin bank
// Assumes: nothing
// Notes: pattern codes select the indicator behaviour
package gbsl_pkg;
    typedef enum logic [1:0] {
        GBSL_PAT_OFF = 2'h0,
        GBSL_PAT_FAST = 2'h1,
        GBSL_PAT_SLOW = 2'h3,
        GBSL_PAT_ON = 2'h2
    } gbsl_pattern_t;
endpackage : gbsl_pkg

/* core/gbsl_blinker.sv */
// Purpose: lamp pattern generator from a reference tick
// Assumes: the internal tick is a one-cycle pulse every TICK_CYC clocks
// Notes: lamp_o is the lamp state, not the pin level
`timescale 1ns/1ps
`include "gbsl_regs.svh"
module gbsl_blinker #(
    parameter int TICK_CYC = `GBSL_TICK_CYC
) (
    input wire logic clk_i,
    input wire logic resetn_i,
    input wire gbsl_pkg::gbsl_pattern_t pattern_i,
    output logic lamp_o
);
    import gbsl_pkg::*;

    localparam logic [11:0] FAST_PER = 12'(`GBSL_FAST_PER_MS / `GBSL_TICK_MS);
    localparam logic [11:0] FAST_ON = 12'(`GBSL_FAST_ON_MS / `GBSL_TICK_MS);
    localparam logic [11:0] SLOW_PER = 12'(`GBSL_SLOW_PER_MS / `GBSL_TICK_MS);
    localparam logic [11:0] SLOW_ON = 12'(`GBSL_SLOW_ON_MS / `GBSL_TICK_MS);
    localparam int DW = $clog2(TICK_CYC + 1);

    logic [DW-1:0] div_ff;
    logic [11:0] per_ff;
    gbsl_pattern_t pat_ff;
    logic lamp_ff;
    wire tick;
    wire restart;
    wire [11:0] per_len;
    wire [11:0] on_len;
    wire per_end;
    wire nxt_lamp;

    // Reference tick divider
    assign tick = (div_ff == DW'(TICK_CYC - 1));
    assign restart = (pattern_i != pat_ff);
    assign per_len = (pat_ff == GBSL_PAT_SLOW) ? SLOW_PER : FAST_PER;
    assign on_len = (pat_ff == GBSL_PAT_SLOW) ? SLOW_ON : FAST_ON;
    assign per_end = (per_ff == per_len - 12'h001);
    // Lamp level per pattern
    assign nxt_lamp = (pat_ff == GBSL_PAT_ON) ? 1'b1 :
                      (pat_ff == GBSL_PAT_OFF) ? 1'b0 :
                      (per_ff < on_len);

    // Divider and period counter, restarted on pattern change
    always_ff @(posedge clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            div_ff <= '0;
            per_ff <= 12'h000;
            pat_ff <= GBSL_PAT_OFF;
            lamp_ff <= 1'b0;
        end
        else
        begin
            pat_ff <= pattern_i;
            lamp_ff <= nxt_lamp;
            if (restart)
            begin
                div_ff <= '0;
                per_ff <= 12'h000;
            end
            else if (tick)
            begin
                div_ff <= '0;
                per_ff <= per_end ? 12'h000 : per_ff + 12'h001;
            end
            else
                div_ff <= div_ff + DW'(1);
        end
    end

    assign lamp_o = lamp_ff;
endmodule : gbsl_blinker

/* bench/gbsl_pad_model.sv */
// Purpose: external pad devices seen by the pin bank
// Assumes: outside drivers yield while the bank drives a pad
// Notes: lamp_o models the inverting lamp transistor stage
`timescale 1ns/1ps
module gbsl_pad_model (
    input wire logic [9:0] drive_i,
    input wire logic [9:0] drive_en_i,
    input wire logic [9:0] ext_i,
    output logic [9:0] pad_o,
    output logic lamp_o
);
    // Resolved pad level, driving side wins
    assign pad_o = (drive_en_i & drive_i) | (~drive_en_i & ext_i);
    // Lamp lit while the pad is low
    assign lamp_o = ~pad_o[0];
endmodule : gbsl_pad_model

/* bench/gbsl_bank_sva.sv */
// Purpose: port checker for the pin bank
// Assumes: pin 0 is the only alternate pin
// Notes: bound to every bank instance
`timescale 1ns/1ps
module gbsl_bank_sva
    import gbsl_pkg::*;
#(
    parameter int NPINS = 10
) (
    input wire logic clk_i,
    input wire logic resetn_i,
    input wire logic [NPINS-1:0] pin_i,
    input wire logic [NPINS-1:0] pin_o,
    input wire logic [NPINS-1:0] pin_oe_o,
    input wire logic [NPINS-1:0] dir_wr_i,
    input wire logic [NPINS-1:0] dir_val_i,
    input wire logic [NPINS-1:0] out_wr_i,
    input wire logic [NPINS-1:0] out_val_i,
    input wire logic rd_i,
    input wire logic [NPINS-1:0] rd_data_o,
    input wire logic rd_valid_o,
    input wire gbsl_pattern_t pattern_i
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!resetn_i);
    // Port relations over time
    rst_quiet_a: assert property (disable iff (1'b0) !resetn_i |->
        pin_oe_o == '0 && !rd_valid_o) else $error("driver on in reset");
    dir_apply_a: assert property (&dir_wr_i ##1 !(|dir_wr_i) |=>
        pin_oe_o[NPINS-1:1] == $past(dir_val_i[NPINS-1:1], 2))
        else $error("direction not applied");
    oe_cause_a: assert property ($changed(pin_oe_o[NPINS-1:1]) |->
        $past(|dir_wr_i[NPINS-1:1], 2)) else $error("stray enable change");
    pin_cause_a: assert property ($changed(pin_o[NPINS-1:1]) |->
        $past(|out_wr_i[NPINS-1:1], 2)) else $error("stray level change");
    out_apply_a: assert property (out_wr_i[5] ##1 !out_wr_i[5] |=>
        !pin_oe_o[5] || pin_o[5] == $past(out_val_i[5], 2))
        else $error("output level wrong");
    rd_pulse_a: assert property (rd_valid_o == $past(rd_i))
        else $error("read valid misplaced");
    rd_hold_a: assert property (!rd_valid_o |-> $stable(rd_data_o))
        else $error("read data moved");
    rd_input_a: assert property (rd_i && !pin_oe_o[7] && !dir_wr_i[7] &&
        !$past(dir_wr_i[7]) |=> rd_data_o[7] == $past(pin_i[7]))
        else $error("input read wrong");
    // Main scenarios
    read_c: cover property (rd_i);
    fast_c: cover property (pattern_i == GBSL_PAT_FAST);
    slow_c: cover property (pattern_i == GBSL_PAT_SLOW);
endmodule : gbsl_bank_sva
bind gbsl_bank gbsl_bank_sva #(.NPINS(NPINS)) gbsl_bank_sva_inst (
    .clk_i(clk_i),
    .resetn_i(resetn_i),
    .pin_i(pin_i),
    .pin_o(pin_o),
    .pin_oe_o(pin_oe_o),
    .dir_wr_i(dir_wr_i),
    .dir_val_i(dir_val_i),
    .out_wr_i(out_wr_i),
    .out_val_i(out_val_i),
    .rd_i(rd_i),
    .rd_data_o(rd_data_o),
    .rd_valid_o(rd_valid_o),
    .pattern_i(pattern_i)
);

/* bench/gbsl_bank_tb.sv */
// Purpose: self-checking bench for the pin bank
// Assumes: reference tick shortened to four cycles
// Notes: pad model closes the loop onto pin_i
`timescale 1ns/1ps
`define CHK(a, b) checks_done++; if ((a) !== (b)) begin num_errors++; \
    $display("ERROR %0t %h %h", $time, a, b); end
module gbsl_bank_tb;
    import gbsl_pkg::*;
    localparam int TK = 4;
    logic clk_i = 0, resetn_i = 1, rd_i = 0, rd_valid_o, lamp_o;
    logic [9:0] pin_i, pin_o, pin_oe_o, rd_data_o, ext_i = 0;
    logic [9:0] dir_wr_i = 0, dir_val_i = 0, alt_wr_i = 0, alt_val_i = 0;
    logic [9:0] out_wr_i = 0, out_val_i = 0;
    gbsl_pattern_t pattern_i = GBSL_PAT_OFF;
    int num_errors = 0, checks_done = 0, seed = 32'h01693097;
    int dir, outv, n, per, on, c;
    int codes[4] = '{0, 1, 3, 2};
    int exp_q[$];
    // Clock and units under test
    always #12.5 clk_i = ~clk_i;
    gbsl_bank #(.TICK_CYC(TK)) gbsl_bank_inst (
        .clk_i(clk_i),
        .resetn_i(resetn_i),
        .pin_i(pin_i),
        .pin_o(pin_o),
        .pin_oe_o(pin_oe_o),
        .dir_wr_i(dir_wr_i),
        .dir_val_i(dir_val_i),
        .alt_wr_i(alt_wr_i),
        .alt_val_i(alt_val_i),
        .out_wr_i(out_wr_i),
        .out_val_i(out_val_i),
        .rd_i(rd_i),
        .rd_data_o(rd_data_o),
        .rd_valid_o(rd_valid_o),
        .pattern_i(pattern_i)
    );
    gbsl_pad_model gbsl_pad_model_inst (
        .drive_i(pin_o),
        .drive_en_i(pin_oe_o),
        .ext_i(ext_i),
        .pad_o(pin_i),
        .lamp_o(lamp_o)
    );
    task automatic cyc(input int k);
        repeat (k) @(negedge clk_i);
    endtask : cyc
    task automatic summarize;
        if (num_errors == 0 && checks_done > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : summarize
    // Random configuration, then indicator patterns
    initial
    begin
        #1 resetn_i = 0;
        cyc(12);
        resetn_i = 1;
        `CHK(pin_oe_o, 10'h000)
        repeat (40)
        begin
            dir_val_i = 10'($random(seed));
            out_val_i = 10'($random(seed));
            alt_val_i = 10'($random(seed)) & 10'h3fe;
            ext_i = 10'($random(seed));
            dir_wr_i = '1; out_wr_i = '1; alt_wr_i = '1;
            dir = dir_val_i; outv = out_val_i;
            cyc(1);
            dir_wr_i = 0; out_wr_i = 0; alt_wr_i = 0;
            cyc(2);
            `CHK(pin_oe_o, 10'(dir))
            `CHK(pin_o & pin_oe_o, 10'(dir & outv))
            exp_q.push_back((dir & outv) | (~dir & int'(ext_i)));
            rd_i = 1;
            cyc(1);
            rd_i = 0;
            `CHK(rd_valid_o, 1'b1)
            `CHK(rd_data_o, 10'(exp_q.pop_front()))
        end
        alt_val_i = 10'h001; alt_wr_i = 10'h001;
        cyc(1);
        alt_wr_i = 0;
        cyc(2);
        `CHK(pin_oe_o[0], 1'b1)
        foreach (codes[i])
        begin
            c = codes[i];
            pattern_i = gbsl_pattern_t'(c);
            per = TK * ((c == 3) ? 3000 : 1000);
            on = TK * ((c == 1) ? 500 : (c == 3) ? 300 : 0);
            on = on + ((c == 2) ? per : 0);
            cyc(3);
            `CHK(lamp_o, 1'(c != 0))
            n = 0;
            repeat (per)
            begin
                @(negedge clk_i);
                n += int'(lamp_o === 1'b1);
            end
            `CHK(n, on)
            cyc(2500);
        end
        summarize();
    end
    // Hang guard
    initial
    begin
        #2000000;
        num_errors++;
        summarize();
    end
endmodule : gbsl_bank_tb
